// ### rtl/tcg_pkg.sv
// package: constants, register layouts and modes of the capture/compare/gated timer
package tcg_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] TCG_OFS_CTL0    = 8'h00;
    localparam logic [7:0] TCG_OFS_CTL1    = 8'h04;
    localparam logic [7:0] TCG_OFS_COUNT   = 8'h08;
    localparam logic [7:0] TCG_OFS_RELOAD  = 8'h0C;
    localparam logic [7:0] TCG_OFS_CAPTURE = 8'h10;
    localparam logic [7:0] TCG_OFS_STATUS  = 8'h14;

    // counter values with a fixed meaning
    localparam logic [15:0] TCG_RESTART_VALUE = 16'h0001;
    localparam logic [15:0] TCG_COUNT_RESET   = 16'h0000;
    localparam logic [15:0] TCG_RELOAD_RESET  = 16'hFFFF;
    localparam logic [15:0] TCG_CAPTURE_RESET = 16'h0000;

    // four-bit mode code: upper bit in control zero, low three bits in control one
    localparam logic [3:0] TCG_MODE_CAPTURE = 4'h4;
    localparam logic [3:0] TCG_MODE_COMPARE = 4'h5;
    localparam logic [3:0] TCG_MODE_GATED   = 4'h6;
    localparam logic [3:0] TCG_MODE_RESTART = 4'hC;

    // interrupt source select codes
    localparam logic [1:0] TCG_IRQ_BOTH    = 2'h0;
    localparam logic [1:0] TCG_IRQ_RELOAD  = 2'h1;
    localparam logic [1:0] TCG_IRQ_CAPTURE = 2'h2;
    localparam logic [1:0] TCG_IRQ_BOTH_B  = 2'h3;

    // control zero register: bit 0 upper mode bit, bits 2:1 irq source, bit 3 cause flag, bit 4 output enable
    typedef struct packed {
        logic       out_enable;
        logic       capture_cause_flag;
        logic [1:0] irq_source_select;
        logic       mode_hi;
    } tcg_ctl0_t;

    // control one register: bit 7 enable, bit 6 polarity, bits 5:3 prescale, bits 2:0 mode low
    typedef struct packed {
        logic       enable;
        logic       input_polarity_bit;
        logic [2:0] prescale;
        logic [2:0] mode_lo;
    } tcg_ctl1_t;

    localparam tcg_ctl0_t TCG_CTL0_RESET = 5'h00;
    localparam tcg_ctl1_t TCG_CTL1_RESET = 8'h00;

    localparam int unsigned TCG_CTL0_WIDTH = 5;
    localparam int unsigned TCG_CTL1_WIDTH = 8;

    typedef enum logic [2:0] {
        TCG_RUN_OFF,
        TCG_RUN_CAPTURE,
        TCG_RUN_RESTART,
        TCG_RUN_COMPARE,
        TCG_RUN_GATED
    } tcg_run_t;

endpackage : tcg_pkg

// ### rtl/tcg_timer.sv
// module: 16-bit timer with capture, capture-restart, compare and gated modes behind an apb slave
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module tcg_timer
    import tcg_pkg::*;
#(
    parameter int unsigned COUNT_WIDTH = 16
) (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        timer_in_in,
    output logic             timer_out_out,
    output logic             timer_irq_out
);

    localparam logic [COUNT_WIDTH-1:0] ONE_VALUE = COUNT_WIDTH'(TCG_RESTART_VALUE);

    // register state
    tcg_ctl0_t               ctl0_reg;
    tcg_ctl1_t               ctl1_reg;
    logic [COUNT_WIDTH-1:0]  count_reg;
    logic [COUNT_WIDTH-1:0]  reload_reg;
    logic [COUNT_WIDTH-1:0]  capture_reg;
    logic [7:0]              pre_cnt_reg;
    logic                    in_meta_reg;
    logic                    in_sync_reg;
    logic                    in_prev_reg;
    logic                    tout_reg;
    logic                    irq_reg;
    logic                    enable_prev_reg;
    logic [31:0]             prdata_reg;
    logic                    pready_reg;
    logic                    pslverr_reg;

    // apb decode
    logic                    apb_setup;
    logic                    apb_write;
    logic                    addr_hit;
    logic [31:0]             read_word;
    logic                    lane_lo;
    logic                    lane_hi;

    // timer events
    tcg_run_t                run_mode;
    logic [3:0]              mode_code;
    logic [7:0]              pre_mask;
    logic                    tick;
    logic                    in_active;
    logic                    in_prev_active;
    logic                    cap_edge;
    logic                    cap_event;
    logic                    match;
    logic                    reload_event;
    logic                    gate_drop;
    logic                    irq_from_cap;
    logic                    irq_from_reload;
    logic [COUNT_WIDTH-1:0]  count_next;

    // ---------------- apb slave ----------------
    assign apb_setup = psel_in && !penable_in && !pready_reg;
    // a write lands only on the access edge where ready is seen high
    assign apb_write = psel_in && penable_in && pready_reg && pwrite_in;
    assign lane_lo   = pstrb_in[0];
    assign lane_hi   = pstrb_in[1];

    always_comb begin
        addr_hit  = 1'b1;
        read_word = 32'h0000_0000;
        unique case (paddr_in)
            TCG_OFS_CTL0:    read_word[TCG_CTL0_WIDTH-1:0] = ctl0_reg;
            TCG_OFS_CTL1:    read_word[TCG_CTL1_WIDTH-1:0] = ctl1_reg;
            TCG_OFS_COUNT:   read_word[COUNT_WIDTH-1:0]    = count_reg;
            TCG_OFS_RELOAD:  read_word[COUNT_WIDTH-1:0]    = reload_reg;
            TCG_OFS_CAPTURE: read_word[COUNT_WIDTH-1:0]    = capture_reg;
            TCG_OFS_STATUS:  read_word[1:0]                = {tout_reg, in_sync_reg};
            default:         addr_hit                      = 1'b0;
        endcase
    end

    // one wait-free access phase: answer is prepared during setup
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= apb_setup;
            pslverr_reg <= apb_setup && !addr_hit;
            if (apb_setup && !pwrite_in) begin
                prdata_reg <= read_word;
            end else if (!apb_setup) begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    // ---------------- input synchroniser ----------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            in_meta_reg <= 1'b0;
            in_sync_reg <= 1'b0;
            in_prev_reg <= 1'b0;
        end else begin
            in_meta_reg <= timer_in_in;
            in_sync_reg <= in_meta_reg;
            in_prev_reg <= in_sync_reg;
        end
    end

    // ---------------- mode decode ----------------
    assign mode_code = {ctl0_reg.mode_hi, ctl1_reg.mode_lo};

    always_comb begin
        run_mode = TCG_RUN_OFF;
        if (ctl1_reg.enable) begin
            if (mode_code == TCG_MODE_CAPTURE) begin
                run_mode = TCG_RUN_CAPTURE;
            end else if (mode_code == TCG_MODE_RESTART) begin
                run_mode = TCG_RUN_RESTART;
            end else if (mode_code == TCG_MODE_COMPARE) begin
                run_mode = TCG_RUN_COMPARE;
            end else if (mode_code == TCG_MODE_GATED) begin
                run_mode = TCG_RUN_GATED;
            end
        end
    end

    // ---------------- prescaler ----------------
    // divide by 2**prescale; unknown mode codes leave the timer idle
    assign pre_mask = 8'((9'h001 << ctl1_reg.prescale) - 9'h001);
    assign tick     = (run_mode != TCG_RUN_OFF) && ((pre_cnt_reg & pre_mask) == pre_mask);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pre_cnt_reg <= 8'h00;
        end else if (run_mode == TCG_RUN_OFF) begin
            pre_cnt_reg <= 8'h00;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
        end
    end

    // ---------------- event detection ----------------
    // polarity 1: rising edge captures and high level gates; polarity 0: the opposite
    assign in_active      = (in_sync_reg == ctl1_reg.input_polarity_bit);
    assign in_prev_active = (in_prev_reg == ctl1_reg.input_polarity_bit);
    assign cap_edge       = in_active && !in_prev_active;
    assign cap_event      = cap_edge && ((run_mode == TCG_RUN_CAPTURE) || (run_mode == TCG_RUN_RESTART));
    assign gate_drop      = (run_mode == TCG_RUN_GATED) && in_prev_active && !in_active;

    // match is taken on a counting tick only, so a stalled gate never repeats it
    assign match          = tick && (count_reg == reload_reg) &&
                            ((run_mode != TCG_RUN_GATED) || in_active);
    assign reload_event   = match;

    always_comb begin
        irq_from_cap    = 1'b0;
        irq_from_reload = 1'b0;
        unique case (ctl0_reg.irq_source_select)
            TCG_IRQ_BOTH,
            TCG_IRQ_BOTH_B: begin
                irq_from_cap    = 1'b1;
                irq_from_reload = 1'b1;
            end
            TCG_IRQ_RELOAD: begin
                irq_from_reload = 1'b1;
            end
            TCG_IRQ_CAPTURE: begin
                irq_from_cap    = 1'b1;
            end
        endcase
    end

    // ---------------- counter ----------------
    always_comb begin
        count_next = count_reg;
        unique case (run_mode)
            TCG_RUN_CAPTURE: begin
                if (tick) begin
                    count_next = count_reg + ONE_VALUE;
                end
            end
            TCG_RUN_RESTART: begin
                if (cap_event || match) begin
                    count_next = ONE_VALUE;
                end else if (tick) begin
                    count_next = count_reg + ONE_VALUE;
                end
            end
            TCG_RUN_COMPARE: begin
                if (tick) begin
                    count_next = count_reg + ONE_VALUE;
                end
            end
            TCG_RUN_GATED: begin
                if (match) begin
                    count_next = ONE_VALUE;
                end else if (tick && in_active) begin
                    count_next = count_reg + ONE_VALUE;
                end
            end
            TCG_RUN_OFF: begin
                count_next = count_reg;
            end
        endcase
    end

    // software write wins; it is only meant to happen while disabled
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_reg <= COUNT_WIDTH'(TCG_COUNT_RESET);
        end else if (apb_write && (paddr_in == TCG_OFS_COUNT)) begin
            if (lane_lo) begin
                count_reg[7:0] <= pwdata_in[7:0];
            end
            if (lane_hi) begin
                count_reg[COUNT_WIDTH-1:8] <= pwdata_in[COUNT_WIDTH-1:8];
            end
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reload_reg <= COUNT_WIDTH'(TCG_RELOAD_RESET);
        end else if (apb_write && (paddr_in == TCG_OFS_RELOAD)) begin
            if (lane_lo) begin
                reload_reg[7:0] <= pwdata_in[7:0];
            end
            if (lane_hi) begin
                reload_reg[COUNT_WIDTH-1:8] <= pwdata_in[COUNT_WIDTH-1:8];
            end
        end
    end

    // ---------------- capture pair ----------------
    // hardware capture wins over a software preset in the same cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            capture_reg <= COUNT_WIDTH'(TCG_CAPTURE_RESET);
        end else if (cap_event) begin
            capture_reg <= count_reg;
        end else if (apb_write && (paddr_in == TCG_OFS_CAPTURE)) begin
            if (lane_lo) begin
                capture_reg[7:0] <= pwdata_in[7:0];
            end
            if (lane_hi) begin
                capture_reg[COUNT_WIDTH-1:8] <= pwdata_in[COUNT_WIDTH-1:8];
            end
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctl1_reg <= TCG_CTL1_RESET;
        end else if (apb_write && (paddr_in == TCG_OFS_CTL1) && lane_lo) begin
            ctl1_reg <= pwdata_in[TCG_CTL1_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctl0_reg <= TCG_CTL0_RESET;
        end else begin
            if (apb_write && (paddr_in == TCG_OFS_CTL0) && lane_lo) begin
                ctl0_reg.out_enable        <= pwdata_in[4];
                ctl0_reg.irq_source_select <= pwdata_in[2:1];
                ctl0_reg.mode_hi           <= pwdata_in[0];
                if (!pwdata_in[3]) begin
                    ctl0_reg.capture_cause_flag <= 1'b0;
                end
            end
            // capture beats both a software clear and a same-cycle reload
            if (cap_event) begin
                ctl0_reg.capture_cause_flag <= 1'b1;
            end else if (reload_event &&
                         ((run_mode == TCG_RUN_CAPTURE) || (run_mode == TCG_RUN_RESTART))) begin
                ctl0_reg.capture_cause_flag <= 1'b0;
            end
        end
    end

    // ---------------- timer output ----------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            enable_prev_reg <= 1'b0;
        end else begin
            enable_prev_reg <= ctl1_reg.enable;
        end
    end

    // while stopped the output rests at the polarity level
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tout_reg <= 1'b0;
        end else if (!ctl1_reg.enable || !enable_prev_reg) begin
            tout_reg <= ctl1_reg.input_polarity_bit;
        end else if (ctl0_reg.out_enable && match &&
                     ((run_mode == TCG_RUN_COMPARE) || (run_mode == TCG_RUN_GATED))) begin
            tout_reg <= !tout_reg;
        end
    end

    // ---------------- interrupt pulse ----------------
    // one-cycle pulse; the system interrupt controller is expected to latch it
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (irq_from_cap && (cap_event || gate_drop)) ||
                       (irq_from_reload && reload_event);
        end
    end

    // a gated-mode deassert shows as an input-capture class event for source selection
    assign prdata_out    = prdata_reg;
    assign pready_out    = pready_reg;
    assign pslverr_out   = pslverr_reg;
    assign timer_out_out = tout_reg;
    assign timer_irq_out = irq_reg;

endmodule // tcg_timer

`default_nettype wire

// ### bench/tcg_timer_monitor.sv
// assertion checker for the capture/compare/gated timer ports
`timescale 1ns/1ps
`default_nettype none

module tcg_timer_monitor
    import tcg_pkg::*;
#(
    parameter int unsigned COUNT_WIDTH = 16
) (
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0]  pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        timer_in_in,
    input wire logic        timer_out_out,
    input wire logic        timer_irq_out
);
    tcg_ctl0_t  c0_reg;
    tcg_ctl1_t  c1_reg;
    logic       wr;
    logic [3:0] mode;
    logic       src_both;
    logic       en_cmp;
    logic       cmp_mute;
    logic       en_gate;
    logic       en_cap;
    logic       pol;

    // shadow of the control registers; the cause flag is not tracked since no property needs it
    assign wr       = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
    assign mode     = {c0_reg.mode_hi, c1_reg.mode_lo};
    assign pol      = c1_reg.input_polarity_bit;
    assign src_both = c0_reg.irq_source_select == TCG_IRQ_BOTH;
    assign en_cmp   = c1_reg.enable && mode == TCG_MODE_COMPARE && c0_reg.out_enable && src_both;
    assign cmp_mute = c1_reg.enable && mode == TCG_MODE_COMPARE && c0_reg.irq_source_select == TCG_IRQ_CAPTURE;
    assign en_gate  = c1_reg.enable && mode == TCG_MODE_GATED && src_both;
    assign en_cap   = c1_reg.enable && (mode == TCG_MODE_CAPTURE || mode == TCG_MODE_RESTART) && src_both;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            c0_reg <= TCG_CTL0_RESET;
        end else if (wr && paddr_in == TCG_OFS_CTL0) begin
            c0_reg <= pwdata_in[4:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            c1_reg <= TCG_CTL1_RESET;
        end else if (wr && paddr_in == TCG_OFS_CTL1) begin
            c1_reg <= pwdata_in[7:0];
        end
    end

    default clocking mon_cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    ready_after_setup_a: assert property (pready_out |-> $past(psel_in && !penable_in))
        else $error("ready without a setup cycle");
    rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data not zero outside access");
    err_with_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error flag without ready");
    out_idle_pol_a: assert property (!c1_reg.enable && !$past(c1_reg.enable) && $stable(pol)
        |-> timer_out_out == pol)
        else $error("idle output differs from polarity");
    cmp_src_mute_a: assert property (cmp_mute && $past(cmp_mute) |-> !timer_irq_out)
        else $error("compare interrupt with capture-only source");
    cmp_toggle_irq_a: assert property (en_cmp && $past(en_cmp) && $past(en_cmp, 2)
        |-> $changed(timer_out_out) == timer_irq_out)
        else $error("compare toggle and interrupt out of step");
    gate_drop_irq_a: assert property (en_gate && $past(en_gate) && $past(timer_in_in) == pol
        && timer_in_in != pol |-> ##[1:6] timer_irq_out)
        else $error("no interrupt after gate input dropped");
    cap_edge_irq_a: assert property (en_cap && $past(en_cap) && $changed(timer_in_in)
        && timer_in_in == pol |-> ##[1:6] timer_irq_out)
        else $error("no interrupt after capture edge");

    cover property (timer_irq_out && mode == TCG_MODE_RESTART);
    cover property (en_cmp && $changed(timer_out_out));
    cover property (en_gate && timer_irq_out && timer_in_in != pol);
endmodule // tcg_timer_monitor

bind tcg_timer tcg_timer_monitor #(.COUNT_WIDTH(COUNT_WIDTH)) u_tcg_mon (
    .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .timer_in_in(timer_in_in), .timer_out_out(timer_out_out), .timer_irq_out(timer_irq_out)
);
`default_nettype wire

// ### bench/tcg_pin_model.sv
// external timer input source with a selectable lag of whole clocks
`timescale 1ns/1ps
`default_nettype none

module tcg_pin_model (
    input  wire logic       clk_in,
    input  wire logic       level_in,
    input  wire logic [3:0] lag_in,
    output logic            pin_out
);
    // preset history so the pin is defined from time zero
    logic [15:0] hist_reg = 16'h0000;

    always_ff @(posedge clk_in) begin
        hist_reg <= {hist_reg[14:0], level_in};
    end

    // pin moves only just after an edge, like a real synchronous source
    assign pin_out = hist_reg[lag_in];
endmodule // tcg_pin_model
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the capture/compare/gated timer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import tcg_pkg::*;
    typedef struct { logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e; } tcg_row_t;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0]  pstrb_in = 4'hF;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        timer_in_in;
    logic        timer_out_out;
    logic        timer_irq_out;
    logic        level = 1'b0;
    logic [3:0]  lag = 4'h0;
    logic [31:0] rd;
    logic [31:0] cap;
    logic        err;
    int          num_errors = 0;
    int          cmp_count = 0;
    tcg_row_t    rows [6] = '{'{TCG_OFS_CTL0, 32'h1F, 32'h17, 1'b0}, '{TCG_OFS_CTL1, 32'h3F, 32'h3F, 1'b0},
        '{TCG_OFS_COUNT, 32'hFFFF1234, 32'h1234, 1'b0}, '{TCG_OFS_RELOAD, 32'hABCD, 32'hABCD, 1'b0},
        '{TCG_OFS_CAPTURE, 32'h5555, 32'h5555, 1'b0}, '{8'h18, 32'h1, 32'h0, 1'b1}};
    logic [7:0]  ra [5] = '{TCG_OFS_CTL0, TCG_OFS_CTL1, TCG_OFS_COUNT, TCG_OFS_RELOAD, TCG_OFS_CAPTURE};
    logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0};

    always #2.5 clk_in = ~clk_in;

    tcg_timer dut (
        .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .timer_in_in(timer_in_in), .timer_out_out(timer_out_out), .timer_irq_out(timer_irq_out)
    );
    tcg_pin_model u_pin (.clk_in(clk_in), .level_in(level), .lag_in(lag), .pin_out(timer_in_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; read data and error are taken at the ready edge only
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // no assumed latency: only the watchdog ends a wait for ready
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wait_irq(input int lim, input logic want);
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (timer_irq_out !== 1'b1 && n < lim);
        chk(timer_irq_out, want);
    endtask

    // timer is left disabled while configured; capture pair is cleared so zero means reload
    task automatic setup(input logic [7:0] c0, input logic [7:0] c1, input logic [15:0] cnt, input logic [15:0] rl);
        apb(1'b1, TCG_OFS_CTL1, {25'h0, c1[6:0]});
        apb(1'b1, TCG_OFS_CTL0, {24'h0, c0});
        apb(1'b1, TCG_OFS_COUNT, {16'h0, cnt});
        apb(1'b1, TCG_OFS_RELOAD, {16'h0, rl});
        apb(1'b1, TCG_OFS_CAPTURE, 32'h0);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic test_done;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            rd_reg(rows[i].a);
            chk(rd, rows[i].r);
            chk(err, rows[i].e);
        end
        // compare: start near the top so the match needs a wrap
        setup(8'h10, 8'h45, 16'hFFFD, 16'h0002);
        rd_reg(TCG_OFS_STATUS);
        chk(rd[1], 1'b1);
        apb(1'b1, TCG_OFS_CTL1, 32'hC5);
        wait_irq(30, 1'b1);
        chk(timer_out_out, 1'b0);
        rd_reg(TCG_OFS_COUNT);
        chk(rd[15:0] > 16'h0002 && rd[15:0] < 16'h0020, 1'b1);
        setup(8'h14, 8'h45, 16'h0000, 16'h0004);
        apb(1'b1, TCG_OFS_CTL1, 32'hC5);
        wait_irq(40, 1'b0);
        // capture without restart
        setup(8'h00, 8'h44, 16'h0000, 16'h0060);
        apb(1'b1, TCG_OFS_CTL1, 32'hC4);
        repeat (10) @(posedge clk_in);
        level <= 1'b1;
        wait_irq(12, 1'b1);
        rd_reg(TCG_OFS_CTL0);
        chk(rd[3], 1'b1);
        rd_reg(TCG_OFS_CAPTURE);
        cap = rd;
        chk(cap[15:0] > 16'h0008 && cap[15:0] < 16'h0030, 1'b1);
        rd_reg(TCG_OFS_COUNT);
        chk(rd[15:0] > cap[15:0], 1'b1);
        level <= 1'b0;
        wait_irq(12, 1'b0);
        rd_reg(TCG_OFS_CAPTURE);
        chk(rd, cap);
        wait_irq(100, 1'b1);
        rd_reg(TCG_OFS_CTL0);
        chk(rd[3], 1'b0);
        rd_reg(TCG_OFS_COUNT);
        chk(rd[15:0] > 16'h0060, 1'b1);
        // capture with restart, slow input source
        lag <= 4'h5;
        setup(8'h01, 8'h44, 16'h0000, 16'h0080);
        apb(1'b1, TCG_OFS_CTL1, 32'hC4);
        repeat (40) @(posedge clk_in);
        level <= 1'b1;
        wait_irq(20, 1'b1);
        rd_reg(TCG_OFS_COUNT);
        chk(rd[15:0] < 16'h0010, 1'b1);
        rd_reg(TCG_OFS_CAPTURE);
        chk(rd[15:0] > 16'h0020, 1'b1);
        level <= 1'b0;
        wait_irq(200, 1'b1);
        rd_reg(TCG_OFS_COUNT);
        chk(rd[15:0] < 16'h0010, 1'b1);
        rd_reg(TCG_OFS_CTL0);
        chk(rd[3], 1'b0);
        // gated counting with output toggle on reload
        lag <= 4'h0;
        setup(8'h10, 8'h46, 16'h0020, 16'h0028);
        apb(1'b1, TCG_OFS_CTL1, 32'hC6);
        repeat (8) @(posedge clk_in);
        rd_reg(TCG_OFS_COUNT);
        chk(rd, 32'h0020);
        level <= 1'b1;
        wait_irq(30, 1'b1);
        rd_reg(TCG_OFS_COUNT);
        chk(rd[15:0] < 16'h0010, 1'b1);
        rd_reg(TCG_OFS_STATUS);
        chk(rd[1], 1'b0);
        level <= 1'b0;
        wait_irq(10, 1'b1);
        rd_reg(TCG_OFS_COUNT);
        cap = rd;
        repeat (10) @(posedge clk_in);
        rd_reg(TCG_OFS_COUNT);
        chk(rd, cap);
        rd_reg(TCG_OFS_STATUS);
        chk(rd[0], 1'b0);
        // capture with reload-only interrupt source: the edge stays silent
        setup(8'h02, 8'h44, 16'h0000, 16'h0040);
        apb(1'b1, TCG_OFS_CTL1, 32'hC4);
        level <= 1'b1;
        wait_irq(12, 1'b0);
        rd_reg(TCG_OFS_CAPTURE);
        chk(rd[15:0] > 16'h0000, 1'b1);
        wait_irq(80, 1'b1);
        // second reset in mid-run
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        foreach (ra[i]) begin
            rd_reg(ra[i]);
            chk(rd, rv[i]);
        end
        chk(timer_out_out, 1'b0);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
